/* File: core/gpb_pkg.sv */
package gpb_pkg;
  localparam int GPB_AW = 12;
  localparam int GPB_DW = 32;
  localparam int GPB_PINS = 8;
  // register byte offsets
  localparam logic [11:0] GPB_OFF_DATA_END = 12'h3FC;
  localparam logic [11:0] GPB_OFF_DIR = 12'h400;
  localparam logic [11:0] GPB_OFF_IS = 12'h404;
  localparam logic [11:0] GPB_OFF_IBE = 12'h408;
  localparam logic [11:0] GPB_OFF_IEV = 12'h40C;
  localparam logic [11:0] GPB_OFF_IM = 12'h410;
  localparam logic [11:0] GPB_OFF_RIS = 12'h414;
  localparam logic [11:0] GPB_OFF_MIS = 12'h418;
  localparam logic [11:0] GPB_OFF_ICR = 12'h41C;
  localparam logic [11:0] GPB_OFF_AFSEL = 12'h420;
  localparam logic [11:0] GPB_OFF_DR2R = 12'h500;
  localparam logic [11:0] GPB_OFF_DR4R = 12'h504;
  localparam logic [11:0] GPB_OFF_DR8R = 12'h508;
  localparam logic [11:0] GPB_OFF_ODR = 12'h50C;
  localparam logic [11:0] GPB_OFF_PUR = 12'h510;
  localparam logic [11:0] GPB_OFF_PDR = 12'h514;
  localparam logic [11:0] GPB_OFF_SLR = 12'h518;
  localparam logic [11:0] GPB_OFF_DEN = 12'h51C;
  localparam logic [11:0] GPB_OFF_ID_BASE = 12'hFD0;
  localparam int GPB_ID_WORDS = 12;
  // address mask field of the data window
  localparam int GPB_MASK_LSB = 2;
  localparam int GPB_MASK_MSB = 9;
  // reset values
  localparam logic [7:0] GPB_RST_ZERO = 8'h00;
  localparam logic [7:0] GPB_RST_DR2R = 8'hFF;
  localparam logic [7:0] GPB_RST_PUR = 8'hFF;
  localparam logic [7:0] GPB_RST_DEN = 8'hFF;

  typedef struct packed {
    logic [7:0] drive_2ma;
    logic [7:0] drive_4ma;
    logic [7:0] drive_8ma;
    logic [7:0] open_drain;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
    logic [7:0] slew_rate;
    logic [7:0] digital_en;
  } gpb_pad_cfg_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpb_alt_drive_t;
endpackage : gpb_pkg

/* File: core/gpb_pin_sync.sv */
`timescale 1ns/100ps
module gpb_pin_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pad_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pad_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule : gpb_pin_sync

/* File: core/gpb_port.sv */
`timescale 1ns/100ps
// Overview of operation
// - direction 0 makes pin input, 1 drives data bit onto pin
// - address bits 9:2 act as per-bit mask on data accesses
// - data register answers at 256 consecutive word addresses
// - data write changes only bits whose address mask bit is 1
// - data read returns zero for bits whose mask bit is 0
// - all unmasked pin interrupts merge into one port interrupt output
// - edge interrupt stays pending until software clears it
// - sense bit 1 selects level, 0 edge; clears on reset
// - both-edges bit 1 triggers on either edge, 0 single edge
// - event bit 0 low/falling, 1 high/rising
// - mask bit enables pin interrupt onto port output
// - raw status ignores mask, masked status shows forwarded ones
// - writing 1 to clear bit clears pending edge, 0 no effect
// - unmasked interrupt on trigger pin pulses the ADC trigger
// - alternate select hands pin control to the peripheral
// - reset gives inputs, alternate off, except debug pins
// - pad selects for drive, pulls, open drain, slew (only on pins with 8mA drive selected), digital enable
// - fixed read-only identification registers
// - data read gives written value for outputs, pin for inputs
module gpb_port
  import gpb_pkg::*;
#(
  parameter logic [7:0] AFSEL_RESET = 8'h00,
  parameter int ADC_PIN = 4,
  // identification bytes, value arbitrary
  parameter logic [95:0] ID_BYTES = 96'h0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe_n,
  output gpb_pad_cfg_t pad_cfg,
  input wire gpb_alt_drive_t alt_drive,
  output logic [7:0] alt_in,
  output logic irq,
  output logic adc_trig
);
  logic [7:0] data_q, dir_q, is_q, ibe_q, iev_q, im_q, afsel_q;
  logic [7:0] dr2_q, dr4_q, dr8_q, odr_q, pur_q, pdr_q, slr_q, den_q;
  logic [7:0] edge_pend_q;
  logic [7:0] lvl, rise, fall, pin_val, raw_st, mis_st, clr_bits;
  logic [7:0] pad_out_q, pad_oe_n_q, alt_in_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, irq_q, adc_trig_q, adc_prev_q;
  logic [31:0] rd_val;
  logic hit, acc, wr;
  gpb_pad_cfg_t pad_cfg_q;

  function automatic logic [7:0] addr_mask(input logic [11:0] a);
    return a[GPB_MASK_MSB:GPB_MASK_LSB];
  endfunction : addr_mask

  function automatic logic in_data(input logic [11:0] a);
    return a <= GPB_OFF_DATA_END;
  endfunction : in_data

  gpb_pin_sync #(.W(GPB_PINS)) u_sync (
    .clk(clk),
    .rst(rst),
    .pad_in(pad_in),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  assign pin_val = lvl & den_q;
  assign acc = psel & penable & pready_q;
  assign wr = acc & pwrite & hit;
  assign clr_bits = (wr && paddr == GPB_OFF_ICR) ? pwdata[7:0] : 8'h00;

  // read decode and map check
  always_comb begin
    rd_val = 32'h0;
    hit = 1'b1;
    if (in_data(paddr)) begin
      rd_val[7:0] = ((dir_q & data_q) | (~dir_q & pin_val))
                    & addr_mask(paddr);
    end else if (paddr >= GPB_OFF_ID_BASE) begin
      rd_val[7:0] = ID_BYTES[8*(paddr[5:2]-4'h4) +: 8];
    end else begin
      case (paddr)
        GPB_OFF_DIR: rd_val[7:0] = dir_q;
        GPB_OFF_IS: rd_val[7:0] = is_q;
        GPB_OFF_IBE: rd_val[7:0] = ibe_q;
        GPB_OFF_IEV: rd_val[7:0] = iev_q;
        GPB_OFF_IM: rd_val[7:0] = im_q;
        GPB_OFF_RIS: rd_val[7:0] = raw_st;
        GPB_OFF_MIS: rd_val[7:0] = mis_st;
        GPB_OFF_ICR: rd_val[7:0] = 8'h00;
        GPB_OFF_AFSEL: rd_val[7:0] = afsel_q;
        GPB_OFF_DR2R: rd_val[7:0] = dr2_q;
        GPB_OFF_DR4R: rd_val[7:0] = dr4_q;
        GPB_OFF_DR8R: rd_val[7:0] = dr8_q;
        GPB_OFF_ODR: rd_val[7:0] = odr_q;
        GPB_OFF_PUR: rd_val[7:0] = pur_q;
        GPB_OFF_PDR: rd_val[7:0] = pdr_q;
        GPB_OFF_SLR: rd_val[7:0] = slr_q;
        GPB_OFF_DEN: rd_val[7:0] = den_q;
        default: hit = 1'b0;
      endcase
    end
  end

  // bus answer: ready in the cycle after setup
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~hit;
      prdata_q <= (psel & ~penable & ~pwrite) ? rd_val : 32'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_q <= GPB_RST_ZERO;
    end else if (wr && in_data(paddr)) begin
      data_q <= (data_q & ~addr_mask(paddr))
                | (pwdata[7:0] & addr_mask(paddr));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_q <= GPB_RST_ZERO;
      is_q <= GPB_RST_ZERO;
      ibe_q <= GPB_RST_ZERO;
      iev_q <= GPB_RST_ZERO;
      im_q <= GPB_RST_ZERO;
      afsel_q <= AFSEL_RESET;
    end else if (wr) begin
      case (paddr)
        GPB_OFF_DIR: dir_q <= pwdata[7:0];
        GPB_OFF_IS: is_q <= pwdata[7:0];
        GPB_OFF_IBE: ibe_q <= pwdata[7:0];
        GPB_OFF_IEV: iev_q <= pwdata[7:0];
        GPB_OFF_IM: im_q <= pwdata[7:0];
        GPB_OFF_AFSEL: afsel_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dr2_q <= GPB_RST_DR2R;
      dr4_q <= GPB_RST_ZERO;
      dr8_q <= GPB_RST_ZERO;
    end else if (wr) begin
      case (paddr)
        GPB_OFF_DR2R: begin
          dr2_q <= pwdata[7:0];
          dr4_q <= dr4_q & ~pwdata[7:0];
          dr8_q <= dr8_q & ~pwdata[7:0];
        end
        GPB_OFF_DR4R: begin
          dr4_q <= pwdata[7:0];
          dr2_q <= dr2_q & ~pwdata[7:0];
          dr8_q <= dr8_q & ~pwdata[7:0];
        end
        GPB_OFF_DR8R: begin
          dr8_q <= pwdata[7:0];
          dr2_q <= dr2_q & ~pwdata[7:0];
          dr4_q <= dr4_q & ~pwdata[7:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      odr_q <= GPB_RST_ZERO;
      pur_q <= GPB_RST_PUR;
      pdr_q <= GPB_RST_ZERO;
      slr_q <= GPB_RST_ZERO;
      den_q <= GPB_RST_DEN;
    end else if (wr) begin
      case (paddr)
        GPB_OFF_ODR: odr_q <= pwdata[7:0];
        GPB_OFF_PUR: pur_q <= pwdata[7:0];
        GPB_OFF_PDR: pdr_q <= pwdata[7:0];
        GPB_OFF_SLR: slr_q <= pwdata[7:0];
        GPB_OFF_DEN: den_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // sticky edge, set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edge_pend_q <= GPB_RST_ZERO;
    end else begin
      for (int i = 0; i < GPB_PINS; i++) begin
        if (!is_q[i] && den_q[i] && (ibe_q[i] ? (rise[i] | fall[i])
            : (iev_q[i] ? rise[i] : fall[i]))) begin
          edge_pend_q[i] <= 1'b1;
        end else if (clr_bits[i]) begin
          edge_pend_q[i] <= 1'b0;
        end
      end
    end
  end

  assign raw_st = (is_q & ~(iev_q ^ pin_val)) | (~is_q & edge_pend_q);
  assign mis_st = raw_st & im_q;

  // one-cycle ADC trigger on new request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
      adc_trig_q <= 1'b0;
      adc_prev_q <= 1'b0;
    end else begin
      irq_q <= |mis_st;
      adc_prev_q <= mis_st[ADC_PIN];
      adc_trig_q <= mis_st[ADC_PIN] & ~adc_prev_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pad_out_q <= 8'h00;
      pad_oe_n_q <= 8'hFF;
      alt_in_q <= 8'h00;
      pad_cfg_q <= '0;
    end else begin
      for (int i = 0; i < GPB_PINS; i++) begin
        if (afsel_q[i]) begin
          pad_out_q[i] <= odr_q[i] ? 1'b0 : alt_drive.out[i];
          pad_oe_n_q[i] <= ~(alt_drive.oe[i] &
                             (~odr_q[i] | ~alt_drive.out[i]));
        end else begin
          pad_out_q[i] <= odr_q[i] ? 1'b0 : data_q[i];
          pad_oe_n_q[i] <= ~(dir_q[i] & (~odr_q[i] | ~data_q[i]));
        end
      end
      alt_in_q <= pin_val & afsel_q;
      pad_cfg_q <= '{drive_2ma: dr2_q, drive_4ma: dr4_q,
                     drive_8ma: dr8_q, open_drain: odr_q,
                     pull_up: pur_q, pull_down: pdr_q,
                     slew_rate: slr_q & dr8_q, digital_en: den_q};
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pad_out = pad_out_q;
  assign pad_oe_n = pad_oe_n_q;
  assign pad_cfg = pad_cfg_q;
  assign alt_in = alt_in_q;
  assign irq = irq_q;
  assign adc_trig = adc_trig_q;

  chk_dir_drive: assert property (@(posedge clk) disable iff (rst)
    ##1 (!$past(afsel_q[0]) && !$past(odr_q[0]))
    |-> pad_oe_n_q[0] == !$past(dir_q[0]))
    else $error("pad enable does not follow direction");

  chk_data_mask_wr: assert property (@(posedge clk) disable iff (rst)
    (wr && in_data(paddr)) |=>
    ((data_q ^ $past(data_q)) & ~$past(addr_mask(paddr))) == 8'h00)
    else $error("masked data bit changed on write");

  chk_data_mask_rd: assert property (@(posedge clk) disable iff (rst)
    (psel && !penable && !pwrite && in_data(paddr)) |=>
    (prdata_q[7:0] & ~addr_mask(paddr)) == 8'h00)
    else $error("masked read bit not zero");

  chk_irq_merge: assert property (@(posedge clk) disable iff (rst)
    (mis_st != 8'h00) |=> irq_q)
    else $error("interrupt missing with masked status set");

  chk_edge_sticky: assert property (@(posedge clk) disable iff (rst)
    (edge_pend_q[0] && !clr_bits[0]) |=> edge_pend_q[0])
    else $error("pending edge lost without clear");

  chk_clear_w1c: assert property (@(posedge clk) disable iff (rst)
    (clr_bits[0] && !rise[0] && !fall[0]) |=> !edge_pend_q[0])
    else $error("clear did not remove pending edge");

  // trigger is a single pulse with the port interrupt
  chk_adc_pulse: assert property (@(posedge clk) disable iff (rst)
    adc_trig_q |-> irq_q ##1 !adc_trig_q)
    else $error("adc trigger without interrupt or longer than one cycle");

  chk_alt_ctrl: assert property (@(posedge clk) disable iff (rst)
    (afsel_q[0] && !odr_q[0]) |=> pad_out_q[0] == $past(alt_drive.out[0]))
    else $error("alternate function not driving pad");

  chk_bus_ready: assert property (@(posedge clk) disable iff (rst)
    (psel && !penable) |=> pready_q ##1 !pready_q)
    else $error("ready not a single access cycle");

  cov_data_write: cover property (@(posedge clk) disable iff (rst)
    wr && in_data(paddr));
  cov_edge_irq: cover property (@(posedge clk) disable iff (rst)
    !irq_q ##1 irq_q);
  cov_adc_trig: cover property (@(posedge clk) disable iff (rst)
    adc_trig_q);
  cov_unmapped: cover property (@(posedge clk) disable iff (rst)
    pslverr_q);
endmodule : gpb_port

/* File: test/gpb_pin_model.sv */
`timescale 1ns/100ps
module gpb_pin_model
  import gpb_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n,
  input wire gpb_pad_cfg_t pad_cfg,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in
);
  logic [7:0] last_q = 8'h00;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_cfg.pull_up[i]) pad_in[i] = 1'b1;
      else if (pad_cfg.pull_down[i]) pad_in[i] = 1'b0;
      else pad_in[i] = ~last_q[i];
    end
  end
  // floating pins toggle so no stale value is seen
  always_ff @(posedge clk) begin
    last_q <= pad_in;
  end
endmodule : gpb_pin_model

/* File: test/gpb_port_tb_top.sv */
`timescale 1ns/100ps
module gpb_port_tb_top;
  import gpb_pkg::*;
  // identification bytes, value arbitrary
  localparam logic [95:0] IDV = 96'hC3B2A1908F7E6D5C4B3A2918;
  localparam logic [11:0] RA [18] = '{GPB_OFF_DATA_END, GPB_OFF_DIR,
    GPB_OFF_IS, GPB_OFF_IBE, GPB_OFF_IEV, GPB_OFF_IM, GPB_OFF_RIS,
    GPB_OFF_MIS, GPB_OFF_ICR, GPB_OFF_AFSEL, GPB_OFF_DR2R, GPB_OFF_DR4R,
    GPB_OFF_DR8R, GPB_OFF_ODR, GPB_OFF_PUR, GPB_OFF_PDR, GPB_OFF_SLR,
    GPB_OFF_DEN};
  localparam logic [7:0] RV [18] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'hFF, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'h00, 8'h00, 8'hFF};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, irq, adc_trig;
  logic [7:0] pad_in, pad_out, pad_oe_n, alt_in, exp_d;
  logic [7:0] ext_en = 8'hFF;
  logic [7:0] ext_val = 8'h00;
  gpb_pad_cfg_t pad_cfg;
  gpb_alt_drive_t alt_drive = '0;
  int error_cnt = 0;
  int cmp_count = 0;
  int n;

  gpb_port #(.AFSEL_RESET(8'h80), .ADC_PIN(4), .ID_BYTES(IDV)) uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_cfg(pad_cfg),
    .alt_drive(alt_drive), .alt_in(alt_in), .irq(irq),
    .adc_trig(adc_trig));

  gpb_pin_model pins (.clk(clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_cfg(pad_cfg), .ext_en(ext_en), .ext_val(ext_val),
    .pad_in(pad_in));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic final_report();
    $display("mismatches %0d, compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string m);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s", $time, m);
      error_cnt++;
    end
  endtask : chk

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask : tick

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      error_cnt++;
      final_report();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] x,
                    input string m);
    apb(1'b0, a, 32'h0);
    chk(q, {24'h0, x}, m);
  endtask : rd

  // mask the pin before changing its detection
  task automatic mode(input logic [7:0] s, b, v, m);
    wr(GPB_OFF_IM, 8'h00);
    wr(GPB_OFF_IS, s);
    wr(GPB_OFF_IBE, b);
    wr(GPB_OFF_IEV, v);
    wr(GPB_OFF_ICR, 8'hFF);
    wr(GPB_OFF_IM, m);
  endtask : mode

  task automatic pin(input logic [7:0] v, input logic [7:0] r);
    ext_val <= v;
    tick(6);
    rd(GPB_OFF_RIS, r, "raw status");
  endtask : pin

  task automatic trig();
    n = 0;
    repeat (10) begin
      @(posedge clk);
      if (adc_trig === 1'b1) n++;
    end
  endtask : trig

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    tick(3);
    for (int i = 0; i < 18; i++) rd(RA[i], RV[i], "reset value");
    chk(pad_oe_n, 8'hFF, "reset enables");
    chk(pad_cfg, 64'hFF000000FF0000FF, "reset pad config");
    apb(1'b0, 12'h600, 32'h0);
    chk({e, q}, {1'b1, 32'h0}, "unmapped access");
    wr(GPB_OFF_RIS, 8'hFF);
    rd(GPB_OFF_RIS, 8'h00, "raw status write");
    for (int k = 0; k < 12; k++) rd(GPB_OFF_ID_BASE + 12'(4 * k),
      IDV[8*k+:8], "ident byte");
    wr(GPB_OFF_ID_BASE, 8'h5A);
    rd(GPB_OFF_ID_BASE, IDV[7:0], "ident write");
    wr(GPB_OFF_DIR, 8'hFF);
    wr(12'h098, 8'hEB);
    rd(GPB_OFF_DATA_END, 8'h22, "masked write");
    rd(12'h0C4, 8'h20, "masked read");
    exp_d = 8'h22;
    for (int m = 0; m < 256; m++) begin
      wr(12'(4 * m), 8'(m) ^ 8'h5A);
      exp_d = (exp_d & ~8'(m)) | ((8'(m) ^ 8'h5A) & 8'(m));
    end
    rd(GPB_OFF_DATA_END, exp_d, "all windows");
    // pin 7 still belongs to its peripheral, which is idle
    chk(pad_out, exp_d & 8'h7F, "pin output");
    chk(pad_oe_n, 8'h80, "output enable");
    wr(GPB_OFF_DIR, 8'h00);
    ext_val <= 8'hA5;
    tick(4);
    rd(GPB_OFF_DATA_END, 8'hA5, "input pins");
    wr(GPB_OFF_DEN, 8'h0F);
    rd(GPB_OFF_DATA_END, 8'h05, "digital enable");
    wr(GPB_OFF_DEN, 8'hFF);
    wr(GPB_OFF_DIR, 8'h01);
    wr(GPB_OFF_ODR, 8'h01);
    wr(12'h004, 8'h01);
    tick(2);
    chk(pad_oe_n, 8'hFF, "open drain high");
    wr(12'h004, 8'h00);
    tick(2);
    chk({pad_oe_n, pad_out[0]}, {8'hFE, 1'b0}, "open drain low");
    wr(GPB_OFF_ODR, 8'h00);
    wr(GPB_OFF_DIR, 8'h00);
    wr(GPB_OFF_DR8R, 8'h01);
    wr(GPB_OFF_SLR, 8'h03);
    rd(GPB_OFF_DR2R, 8'hFE, "drive exclusive");
    chk(pad_cfg.slew_rate, 8'h01, "slew with 8mA");
    ext_val <= 8'h00;
    tick(4);
    mode(8'h00, 8'h00, 8'h01, 8'h01);
    pin(8'h01, 8'h01);
    rd(GPB_OFF_MIS, 8'h01, "masked status");
    chk(irq, 1'b1, "port interrupt");
    pin(8'h00, 8'h01);
    wr(GPB_OFF_ICR, 8'h00);
    rd(GPB_OFF_RIS, 8'h01, "clear with zero");
    wr(GPB_OFF_ICR, 8'h01);
    rd(GPB_OFF_RIS, 8'h00, "clear with one");
    chk(irq, 1'b0, "interrupt dropped");
    mode(8'h00, 8'h00, 8'h00, 8'h01);
    pin(8'h01, 8'h00);
    pin(8'h00, 8'h01);
    mode(8'h00, 8'h01, 8'h00, 8'h01);
    pin(8'h01, 8'h01);
    wr(GPB_OFF_ICR, 8'h01);
    pin(8'h00, 8'h01);
    mode(8'h00, 8'h00, 8'h01, 8'h00);
    pin(8'h01, 8'h01);
    rd(GPB_OFF_MIS, 8'h00, "masked off");
    chk(irq, 1'b0, "masked interrupt");
    mode(8'h01, 8'h00, 8'h01, 8'h01);
    rd(GPB_OFF_RIS, 8'h01, "high level");
    chk(irq, 1'b1, "level interrupt");
    pin(8'h00, 8'h00);
    mode(8'h01, 8'h00, 8'h00, 8'h01);
    rd(GPB_OFF_RIS, 8'h01, "low level");
    pin(8'h01, 8'h00);
    mode(8'h00, 8'h00, 8'h10, 8'h10);
    ext_val <= 8'h11;
    trig();
    chk(n, 1, "trigger pulse");
    chk(irq, 1'b1, "trigger interrupt");
    wr(GPB_OFF_IM, 8'h00);
    ext_val <= 8'h01;
    tick(4);
    wr(GPB_OFF_ICR, 8'hFF);
    ext_val <= 8'h11;
    trig();
    chk(n, 0, "masked trigger");
    alt_drive <= {8'h01, 8'h01};
    wr(GPB_OFF_AFSEL, 8'h81);
    tick(5);
    chk({pad_oe_n, pad_out[0]}, {8'hFE, 1'b1}, "alt drive");
    chk(alt_in, 8'h01, "alt input");
    ext_en <= 8'h00;
    tick(4);
    rd(GPB_OFF_DATA_END, 8'hFF, "pull-up level");
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(3);
    rd(GPB_OFF_AFSEL, 8'h80, "reset alt select");
    rd(GPB_OFF_DIR, 8'h00, "reset direction");
    final_report();
  end
endmodule : gpb_port_tb_top
